// File: core/mcp_ctrl.v
// Module control pins: two-wire slave, reset pin filter, init timer, alarms, pin outputs.
// Assumes all pin inputs are asynchronous; lane levels come from logic on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defines.vh"
module mcp_ctrl
#(
    parameter [31:0] INIT_CYC = `MCP_INIT_CYC
)
(
    input wire clk_sys_i,
    input wire nrst_i,
    input wire module_select_n_i,
    input wire module_reset_n_i,
    input wire low_power_select_i,
    input wire tx_output_disable_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    output wire interrupt_n_o,
    output wire interrupt_n_oe_o,
    output wire presence_n_o,
    output wire presence_n_oe_o,
    input wire [31:0] optical_monitor_i,
    output reg rx_signal_loss_alarm_o,
    output reg [3:0] tx_disable_o,
    output reg high_power_en_o,
    output reg init_pending_flag_o
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_AACK = 3'd2;
    localparam [2:0] ST_WRITE = 3'd3;
    localparam [2:0] ST_WACK = 3'd4;
    localparam [2:0] ST_READ = 3'd5;
    localparam [2:0] ST_RACK = 3'd6;
    localparam integer RST_MIN_W = `MCP_RST_MIN_CYC;
    localparam [15:0] RST_MIN = RST_MIN_W[15:0];
    // Pin synchronisers: sel, rst, lp, txdis, scl, sda
    reg [5:0] pin_meta_r;
    reg [5:0] pin_sync_r;
    reg scl_q_r;
    reg sda_q_r;
    wire sel_n = pin_sync_r[5];
    wire rst_pin_n = pin_sync_r[4];
    wire lp_sel = pin_sync_r[3];
    wire txdis_pin = pin_sync_r[2];
    wire scl_s = pin_sync_r[1];
    wire sda_s = pin_sync_r[0];
    always @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            pin_meta_r <= 6'h3f;
            pin_sync_r <= 6'h3f;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            pin_meta_r <= {module_select_n_i, module_reset_n_i, low_power_select_i,
                           tx_output_disable_i, scl_i, sda_i};
            pin_sync_r <= pin_meta_r;
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end
    wire scl_rise = scl_s & ~scl_q_r;
    wire scl_fall = ~scl_s & scl_q_r;
    wire bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
    wire bus_stop = scl_s & scl_q_r & ~sda_q_r & sda_s;
    // Reset pin filter: only a low level held past the minimum takes effect
    reg [15:0] rst_cnt_r;
    reg rst_hold_r;
    always @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            rst_cnt_r <= 16'h0000;
            rst_hold_r <= 1'b0;
        end
        else if (rst_pin_n)
        begin
            rst_cnt_r <= 16'h0000;
            rst_hold_r <= 1'b0;
        end
        else if (rst_cnt_r == RST_MIN)
            rst_hold_r <= 1'b1;
        else
            rst_cnt_r <= rst_cnt_r + 16'h0001;
    end
    // Power-on and accepted pulse both restart the settings and the init timer
    wire set_rst = ~nrst_i | rst_hold_r;
    // Init timer
    reg [31:0] init_cnt_r;
    reg init_pend_r;
    wire init_end = init_pend_r & (init_cnt_r == INIT_CYC - 32'd1);
    always @(posedge clk_sys_i)
    begin
        if (set_rst)
        begin
            init_cnt_r <= 32'h00000000;
            init_pend_r <= 1'b1;
        end
        else if (init_pend_r)
        begin
            init_cnt_r <= init_cnt_r + 32'h00000001;
            if (init_end)
                init_pend_r <= 1'b0;
        end
    end
    // Serial slave state
    reg [2:0] st_r;
    reg [2:0] bit_cnt_r;
    reg [7:0] shreg_r;
    reg [7:0] ptr_r;
    reg got_r;
    reg first_r;
    reg rd_mode_r;
    reg sda_oe_r;
    reg wr_stb_r;
    reg [7:0] wr_addr_r;
    reg [7:0] wr_data_r;
    reg flag_rd_r;
    reg [7:0] ctrl_r;
    reg [7:0] thr_r;
    reg flag_done_r;
    reg [3:0] flag_los_r;
    reg [3:0] lane_low_r;
    wire [7:0] mem_rdata;
    reg [7:0] rd_byte;
    // Read data for the current pointer
    always @*
    begin
        rd_byte = 8'h00;
        if (ptr_r[7:4] == `MCP_OFS_MEM)
            rd_byte = mem_rdata;
        else
            case (ptr_r)
                `MCP_OFS_STATUS: rd_byte = {7'h00, init_pend_r};
                `MCP_OFS_FLAGS: rd_byte = {3'h0, flag_los_r, flag_done_r};
                `MCP_OFS_LEVEL0: rd_byte = optical_monitor_i[7:0];
                8'h03: rd_byte = optical_monitor_i[15:8];
                8'h04: rd_byte = optical_monitor_i[23:16];
                8'h05: rd_byte = optical_monitor_i[31:24];
                `MCP_OFS_CTRL: rd_byte = ctrl_r;
                `MCP_OFS_THR: rd_byte = thr_r;
                default: rd_byte = 8'h00;
            endcase
    end
    always @(posedge clk_sys_i)
    begin
        wr_stb_r <= 1'b0;
        flag_rd_r <= 1'b0;
        if (set_rst || sel_n)
        begin
            // Deselect drops any transfer and releases the data line
            st_r <= ST_IDLE;
            bit_cnt_r <= 3'd7;
            shreg_r <= 8'h00;
            got_r <= 1'b0;
            first_r <= 1'b0;
            rd_mode_r <= 1'b0;
            sda_oe_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            if (set_rst)
                ptr_r <= 8'h00;
        end
        else if (bus_start)
        begin
            st_r <= ST_ADDR;
            bit_cnt_r <= 3'd7;
            got_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else if (bus_stop)
        begin
            st_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end
        else
            case (st_r)
                ST_ADDR, ST_WRITE:
                    if (scl_rise)
                    begin
                        shreg_r <= {shreg_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r - 3'd1;
                        if (bit_cnt_r == 3'd0)
                            got_r <= 1'b1;
                    end
                    else if (scl_fall && got_r)
                    begin
                        got_r <= 1'b0;
                        if (st_r == ST_WRITE)
                        begin
                            st_r <= ST_WACK;
                            sda_oe_r <= 1'b1;
                            if (first_r)
                                ptr_r <= shreg_r;
                            else
                            begin
                                wr_stb_r <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= shreg_r;
                                ptr_r <= ptr_r + 8'h01;
                            end
                            first_r <= 1'b0;
                        end
                        else if (shreg_r[7:1] == `MCP_DEV_ADDR)
                        begin
                            st_r <= ST_AACK;
                            sda_oe_r <= 1'b1;
                            rd_mode_r <= shreg_r[0];
                        end
                        else
                            st_r <= ST_IDLE;
                    end
                ST_AACK, ST_WACK, ST_RACK:
                    if (scl_rise && st_r == ST_RACK && sda_s)
                        st_r <= ST_IDLE;
                    else if (scl_fall)
                    begin
                        bit_cnt_r <= 3'd7;
                        if (st_r == ST_AACK && !rd_mode_r)
                        begin
                            st_r <= ST_WRITE;
                            first_r <= 1'b1;
                            sda_oe_r <= 1'b0;
                        end
                        else if (st_r == ST_WACK)
                        begin
                            st_r <= ST_WRITE;
                            sda_oe_r <= 1'b0;
                        end
                        else
                        begin
                            st_r <= ST_READ;
                            shreg_r <= rd_byte;
                            sda_oe_r <= ~rd_byte[7];
                            flag_rd_r <= (ptr_r == `MCP_OFS_FLAGS);
                        end
                    end
                ST_READ:
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == 3'd0)
                        begin
                            st_r <= ST_RACK;
                            sda_oe_r <= 1'b0;
                            ptr_r <= ptr_r + 8'h01;
                        end
                        else
                        begin
                            bit_cnt_r <= bit_cnt_r - 3'd1;
                            shreg_r <= {shreg_r[6:0], 1'b0};
                            sda_oe_r <= ~shreg_r[6];
                        end
                    end
                default:
                    st_r <= ST_IDLE;
            endcase
    end
    mcp_mem u_mem
    (
        .clk_sys_i(clk_sys_i),
        .we_i(wr_stb_r && (wr_addr_r[7:4] == `MCP_OFS_MEM)),
        .waddr_i(wr_addr_r[3:0]),
        .wdata_i(wr_data_r),
        .raddr_i(ptr_r[3:0]),
        .rdata_o(mem_rdata)
    );
    // Per-lane threshold compare
    genvar gi;
    generate
        for (gi = 0; gi < `MCP_LANES; gi = gi + 1)
        begin : g_lane
            always @(posedge clk_sys_i)
            begin
                if (set_rst)
                    lane_low_r[gi] <= 1'b0;
                else
                    lane_low_r[gi] <= (optical_monitor_i[gi*8 +: 8] < thr_r);
            end
        end
    endgenerate
    // Settings and sticky flags; a set in the read cycle survives the clear
    always @(posedge clk_sys_i)
    begin
        if (set_rst)
        begin
            ctrl_r <= `MCP_CTRL_RST;
            thr_r <= `MCP_THR_RST;
            flag_done_r <= 1'b0;
            flag_los_r <= 4'h0;
        end
        else
        begin
            if (wr_stb_r && wr_addr_r == `MCP_OFS_CTRL)
                ctrl_r <= wr_data_r;
            if (wr_stb_r && wr_addr_r == `MCP_OFS_THR)
                thr_r <= wr_data_r;
            flag_done_r <= (flag_done_r & ~flag_rd_r) | init_end;
            flag_los_r <= (flag_los_r & {4{~flag_rd_r}}) | lane_low_r;
        end
    end
    // Pin outputs
    reg irq_r;
    always @(posedge clk_sys_i)
    begin
        if (set_rst)
        begin
            irq_r <= 1'b0;
            rx_signal_loss_alarm_o <= 1'b0;
            tx_disable_o <= 4'hf;
            high_power_en_o <= 1'b0;
            init_pending_flag_o <= 1'b1;
        end
        else
        begin
            irq_r <= flag_done_r | (|flag_los_r);
            rx_signal_loss_alarm_o <= |lane_low_r;
            tx_disable_o <= {4{txdis_pin}} | ctrl_r[3:0];
            // Full power only once init is over and low power is not asked for
            high_power_en_o <= ~lp_sel & ~init_pend_r;
            init_pending_flag_o <= init_pend_r;
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_r;
    assign interrupt_n_o = 1'b0;
    assign interrupt_n_oe_o = irq_r;
    assign presence_n_o = 1'b0;
    assign presence_n_oe_o = 1'b1;
endmodule
`default_nettype wire

// File: core/mcp_defines.vh
// Constants for the module control pins block: offsets, fields, resets, timing.
// Assumes a 250 MHz system clock and a two-wire host that drives the clock pin.
// Functional notes
// - Two-wire commands are answered only while module_select_n is low.
// - An accepted reset pulse returns every setting to its default.
// - On reset completion, raise interrupt_n and clear init_pending_flag.
// - After power up the completion interrupt is raised without a reset pulse.
// - Loss alarm asserts when any of the 4 lane levels is below threshold.
// - Transmitter is off when the pin or the serial disable asks for it.
// - Each lane level from optical_monitor is readable over the serial bus.
// - interrupt_n is pulled low for faults or critical status.
// - interrupt_n is open collector: only pulled low, never driven high.
// - Maximum power is limited according to low_power_select.
// - presence_n is tied to ground while the module is present.
// - Seven low-speed pins: select, clock, data, reset, low power, presence, interrupt.
// - Fully functional no later than 2000 ms after supply is good.
`ifndef MCP_DEFINES_VH
`define MCP_DEFINES_VH
`define MCP_CLK_MHZ 250
`define MCP_INIT_MS 2000
`define MCP_INIT_CYC (`MCP_INIT_MS * 1000 * `MCP_CLK_MHZ)
`define MCP_RST_MIN_NS 2000
`define MCP_RST_MIN_CYC ((`MCP_RST_MIN_NS * `MCP_CLK_MHZ + 999) / 1000)
`define MCP_DEV_ADDR 7'h50
`define MCP_LANES 4
`define MCP_OFS_STATUS 8'h00
`define MCP_OFS_FLAGS 8'h01
`define MCP_OFS_LEVEL0 8'h02
`define MCP_OFS_CTRL 8'h06
`define MCP_OFS_THR 8'h07
`define MCP_OFS_MEM 4'h1
`define MCP_CTRL_RST 8'h00
`define MCP_THR_RST 8'h10
`define MCP_FLG_DONE 0
`define MCP_FLG_LOS 1
`endif

// File: core/mcp_mem.v
// Sixteen-byte user memory reached over the serial bus.
// Assumes one writer and one reader on the system clock; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module mcp_mem
(
    input wire clk_sys_i,
    input wire we_i,
    input wire [3:0] waddr_i,
    input wire [7:0] wdata_i,
    input wire [3:0] raddr_i,
    output reg [7:0] rdata_o
);
    reg [7:0] mem_r [0:15];

    // Contents survive resets; only the register settings have defaults
    always @(posedge clk_sys_i)
    begin
        if (we_i)
            mem_r[waddr_i] <= wdata_i;
        rdata_o <= mem_r[raddr_i];
    end
endmodule
`default_nettype wire

// File: tb/mcp_ctrl_properties.sv
// Pin-level checker for mcp_ctrl, bound to every instance.
// Assumes the synchronous active-low nrst_i on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module mcp_ctrl_properties
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic module_select_n_i,
    input wire logic low_power_select_i,
    input wire logic tx_output_disable_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic interrupt_n_o,
    input wire logic interrupt_n_oe_o,
    input wire logic presence_n_o,
    input wire logic presence_n_oe_o,
    input wire logic [31:0] optical_monitor_i,
    input wire logic rx_signal_loss_alarm_o,
    input wire logic [3:0] tx_disable_o,
    input wire logic high_power_en_o,
    input wire logic init_pending_flag_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!nrst_i);
pres_ground_a: assert property (presence_n_oe_o && !presence_n_o)
    else $error("presence pin not grounded");
open_drain_a: assert property (!interrupt_n_o && !sda_o)
    else $error("open-drain pin driven high");
sel_release_a: assert property (module_select_n_i [*6] |-> !sda_oe_o)
    else $error("data driven while deselected");
rst_default_a: assert property ($rose(nrst_i) |->
    tx_disable_o == 4'hf && init_pending_flag_o
    && !interrupt_n_oe_o && !high_power_en_o && !sda_oe_o)
    else $error("outputs not at defaults after reset");
init_int_a: assert property ($fell(init_pending_flag_o) |-> ##[0:2] interrupt_n_oe_o)
    else $error("no interrupt on init completion");
txdis_pin_a: assert property (tx_output_disable_i [*4] |-> tx_disable_o == 4'hf)
    else $error("tx lanes on while pin disables");
low_power_a: assert property (low_power_select_i [*4] |-> !high_power_en_o)
    else $error("full power in low power mode");
// Level zero is below any threshold the bench uses
los_zero_a: assert property (
    (optical_monitor_i[7:0] == 8'h00 && !init_pending_flag_o) [*3] |-> rx_signal_loss_alarm_o)
    else $error("no alarm on dark lane");
cover property ($fell(init_pending_flag_o));
cover property ($rose(sda_oe_o));
cover property ($rose(rx_signal_loss_alarm_o));
endmodule
bind mcp_ctrl mcp_ctrl_properties u_props (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .module_select_n_i(module_select_n_i), .low_power_select_i(low_power_select_i),
    .tx_output_disable_i(tx_output_disable_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .interrupt_n_o(interrupt_n_o), .interrupt_n_oe_o(interrupt_n_oe_o),
    .presence_n_o(presence_n_o), .presence_n_oe_o(presence_n_oe_o),
    .optical_monitor_i(optical_monitor_i), .rx_signal_loss_alarm_o(rx_signal_loss_alarm_o),
    .tx_disable_o(tx_disable_o), .high_power_en_o(high_power_en_o),
    .init_pending_flag_o(init_pending_flag_o));
`default_nettype wire

// File: tb/mcp_host.sv
// Host board controller model: two-wire master, open-drain data drive.
// Assumes the bench resolves the data wire with a pull-up; clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module mcp_host
(
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_oe_o
);
initial
begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
end
task automatic start;
    begin
        sda_oe_o = 1'b0;
        #40 scl_o = 1'b1;
        #40 sda_oe_o = 1'b1;
        #40 scl_o = 1'b0;
        #40;
    end
endtask
// Data changes mid-low, sampled mid-high 40 ns after the rise: 160 ns a bit
task automatic bitx(input logic b, output logic r);
    begin
        sda_oe_o = !b;
        #40 scl_o = 1'b1;
        #40 r = sda_i;
        #40 scl_o = 1'b0;
        #40;
    end
endtask
task automatic stop;
    begin
        sda_oe_o = 1'b1;
        #40 scl_o = 1'b1;
        #40 sda_oe_o = 1'b0;
        #80;
    end
endtask
task automatic xfer(input logic [7:0] d, input logic n, output logic [7:0] q, output logic a);
    integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bitx(d[i], q[i]);
        bitx(n, a);
    end
endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Bench for mcp_ctrl with a two-wire host model on the data and clock pins.
// Assumes the init timer is shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
logic clk_sys_i = 1'b0;
logic nrst = 1'b0;
logic sel_n = 1'b0; // Own select line for this module
logic mrst_n = 1'b1;
logic lp = 1'b0;
logic txd = 1'b0;
logic [31:0] mon = 32'h20202020;
logic [7:0] q;
logic a;
integer bad_count = 0;
integer samples_checked = 0;
integer cyc = 0;
wire scl, h_oe, s_oe, s_o, i_o, i_oe, p_o, p_oe, alarm, hp, initp;
wire [3:0] txdo;
wire sda = !(h_oe || s_oe); // Pull-up wins when nobody pulls low
always #2 clk_sys_i = !clk_sys_i;
mcp_ctrl #(.INIT_CYC(32'd20)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst),
    .module_select_n_i(sel_n), .module_reset_n_i(mrst_n), .low_power_select_i(lp),
    .tx_output_disable_i(txd), .scl_i(scl), .sda_i(sda), .sda_o(s_o), .sda_oe_o(s_oe),
    .interrupt_n_o(i_o), .interrupt_n_oe_o(i_oe), .presence_n_o(p_o), .presence_n_oe_o(p_oe),
    .optical_monitor_i(mon), .rx_signal_loss_alarm_o(alarm), .tx_disable_o(txdo),
    .high_power_en_o(hp), .init_pending_flag_o(initp));
mcp_host host (.sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
task complete_run;
    begin
        $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
endtask
always @(posedge clk_sys_i)
begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
        bad_count = bad_count + 1;
        complete_run;
    end
end
task chk(input logic [7:0] g, input logic [7:0] e);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("ERROR %0t byte %h want %h", $time, g, e);
        end
    end
endtask
task chk1(input logic g, input logic e);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("ERROR %0t bit %b want %b", $time, g, e);
        end
    end
endtask
task wt(input integer n);
    repeat (n) @(negedge clk_sys_i);
endtask
task w_init;
    integer k;
    begin
        k = 0;
        while (initp !== 1'b0 && k < 200)
        begin
            @(negedge clk_sys_i);
            k = k + 1;
        end
    end
endtask
task wr(input logic [7:0] o, input logic [7:0] d);
    begin
        host.start;
        host.xfer(8'ha0, 1'b1, q, a);
        host.xfer(o, 1'b1, q, a);
        host.xfer(d, 1'b1, q, a);
        host.stop;
    end
endtask
// Pointer write, repeated start, one byte read ended by NACK
task rd(input logic [7:0] o);
    logic [7:0] t;
    begin
        host.start;
        host.xfer(8'ha0, 1'b1, t, a);
        host.xfer(o, 1'b1, t, a);
        host.start;
        host.xfer(8'ha1, 1'b1, t, a);
        host.xfer(8'hff, 1'b1, q, a);
        host.stop;
    end
endtask
task t_init;
    begin
        chk1(initp, 1'b1);
        chk1(hp, 1'b0);
        w_init; // Status ignored until done
        chk1(initp, 1'b0);
        wt(3);
        chk1(i_oe, 1'b1);
        rd(8'h00);
        chk(q, 8'h00);
        rd(8'h01); // Source of interrupt
        chk1(q[0], 1'b1);
        wt(3);
        chk1(i_oe, 1'b0);
        chk1(hp, 1'b1);
    end
endtask
task t_sel;
    begin
        sel_n = 1'b1;
        wt(4);
        host.start;
        host.xfer(8'ha0, 1'b1, q, a);
        chk1(a, 1'b1);
        host.stop;
        sel_n = 1'b0;
        wt(4);
        host.start;
        host.xfer(8'ha0, 1'b1, q, a);
        chk1(a, 1'b0);
        host.stop;
    end
endtask
task t_alarm;
    integer i;
    begin
        chk1(alarm, 1'b0);
        mon = 32'h24230f21;
        wt(3);
        chk1(alarm, 1'b1);
        mon = 32'h24231021;
        wt(3);
        chk1(alarm, 1'b0);
        // Dark lane zero
        mon = 32'h24231000;
        wt(4);
        chk1(alarm, 1'b1);
        mon = 32'h24231021;
        wr(8'h07, 8'h30);
        wt(4);
        chk1(alarm, 1'b1);
        chk1(i_oe, 1'b1);
        for (i = 0; i < 4; i = i + 1)
        begin
            rd(8'h02 + i[7:0]);
            chk(q, mon[i*8 +: 8]);
        end
        // All four lanes under the raised threshold stay latched
        rd(8'h01);
        chk(q, 8'h1e);
    end
endtask
task t_tx;
    begin
        txd = 1'b1;
        wt(4);
        chk({4'h0, txdo}, 8'h0f);
        txd = 1'b0;
        wt(4);
        chk({4'h0, txdo}, 8'h00);
        wr(8'h06, 8'h05);
        wt(4);
        chk({4'h0, txdo}, 8'h05);
        lp = 1'b1;
        wt(4);
        chk1(hp, 1'b0);
        lp = 1'b0;
        wt(4);
        chk1(hp, 1'b1);
        wr(8'h12, 8'ha5);
        rd(8'h12);
        chk(q, 8'ha5);
    end
endtask
task t_mrst;
    begin
        mrst_n = 1'b0;
        wt(400);
        mrst_n = 1'b1;
        wt(10);
        chk1(initp, 1'b0);
        rd(8'h07);
        chk(q, 8'h30);
        mrst_n = 1'b0;
        wt(600); // Longer than the minimum pulse
        chk({4'h0, txdo}, 8'h0f);
        chk1(initp, 1'b1);
        mrst_n = 1'b1;
        w_init;
        wt(3);
        chk1(i_oe, 1'b1);
        rd(8'h07);
        chk(q, 8'h10);
        rd(8'h06);
        chk(q, 8'h00);
        chk({4'h0, txdo}, 8'h00);
    end
endtask
initial
begin
    wt(3);
    nrst = 1'b1;
    wt(3);
    t_init;
    t_sel;
    t_alarm;
    t_tx;
    t_mrst;
    complete_run;
end
endmodule
`default_nettype wire
